// ### rtl/lcc_pkg.sv
package lcc_pkg;

    // ----------------------------------------
    // opcodes
    // ----------------------------------------
    localparam logic [7:0] OP_INTEG = 8'hC1;
    localparam logic [7:0] OP_FRAMES = 8'hC2;
    localparam logic [7:0] OP_MODE = 8'hC3;
    localparam logic [7:0] OP_ADVANCE = 8'hC4;
    localparam logic [7:0] OP_TRIG_EN = 8'hE1;
    localparam logic [7:0] OP_DARK = 8'hC5;
    localparam logic [7:0] OP_DUMMY = 8'hC9;

    // ----------------------------------------
    // replies
    // ----------------------------------------
    localparam logic [7:0] REPLY_ACK = 8'h06;
    localparam logic [7:0] REPLY_NACK = 8'h15;

    // ----------------------------------------
    // ranges and reset values
    // ----------------------------------------
    localparam logic [31:0] INTEG_MIN = 32'h0000000A;
    localparam logic [31:0] INTEG_MAX = 32'h03938700;
    localparam logic [31:0] INTEG_RST = 32'h00001388;
    localparam logic [31:0] SHUTTER_MAX = 32'h00000E7D;
    localparam logic [31:0] FRAMES_MIN = 32'h00000001;
    localparam logic [31:0] FRAMES_MAX = 32'h000011F7;
    localparam logic [31:0] FRAMES_MAX_DUMMY = 32'h000011BD;
    localparam logic [31:0] FRAMES_RST = 32'h00000001;
    localparam logic [31:0] ADVANCE_MAX = 32'h00000739;
    localparam logic [31:0] ADVANCE_RST = 32'h00000000;
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [2:0] MODE_MAX = 3'h4;
    localparam logic [2:0] MODE_EXT_SYNC = 3'h4;

    typedef enum logic [2:0]
    {
        LCC_MODE_INT_SW = 3'h0,
        LCC_MODE_INT_HW_START = 3'h1,
        LCC_MODE_INT_HW_ENABLE = 3'h2,
        LCC_MODE_SINGLE_SHOT = 3'h3,
        LCC_MODE_EXT_SYNC = 3'h4
    } lcc_mode_t;

    function automatic logic [2:0] lcc_data_len(input logic [7:0] op);
        case (op)
            OP_INTEG, OP_FRAMES, OP_ADVANCE: lcc_data_len = 3'h4;
            OP_MODE, OP_TRIG_EN, OP_DARK, OP_DUMMY: lcc_data_len = 3'h1;
            default: lcc_data_len = 3'h0;
        endcase
    endfunction

    function automatic logic lcc_in_range(input logic [31:0] v, input logic [31:0] lo,
        input logic [31:0] hi);
        lcc_in_range = (v >= lo) && (v <= hi);
    endfunction

endpackage

// ### rtl/lcc_cmd_if.sv
`timescale 1ns/1ps
// carries one assembled command from the byte collector to the decoder
interface lcc_cmd_if;
    logic valid;
    logic [7:0] opcode;
    logic [31:0] data;
    logic known;
    logic [7:0] reply;
    logic reply_valid;

    modport collector
    (
        output valid,
        output opcode,
        output data,
        output known
    );
    modport decoder
    (
        input valid,
        input opcode,
        input data,
        input known,
        output reply,
        output reply_valid
    );
    modport sender
    (
        input reply,
        input reply_valid
    );
endinterface

// ### rtl/lcc_collector.sv
`timescale 1ns/1ps
module lcc_collector
    import lcc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic busy,
    output logic rx_ready,
    lcc_cmd_if.collector cmd
);
    typedef enum logic [1:0] {LCC_C_OP, LCC_C_DATA, LCC_C_DONE} lcc_cstate_t;

    lcc_cstate_t state_ff;
    logic [7:0] opcode_ff;
    logic [31:0] data_ff;
    logic [2:0] left_ff;
    logic known_ff;
    logic [2:0] len;

    assign len = lcc_data_len(rx_data);
    // stalls the source while a reply is still outstanding
    assign rx_ready = (state_ff != LCC_C_DONE) && !busy;
    assign cmd.valid = (state_ff == LCC_C_DONE);
    assign cmd.opcode = opcode_ff;
    assign cmd.data = data_ff;
    assign cmd.known = known_ff;

    // ----------------------------------------
    // byte gathering
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            state_ff <= LCC_C_OP;
            opcode_ff <= 8'h00;
            data_ff <= 32'h00000000;
            left_ff <= 3'h0;
            known_ff <= 1'b0;
        end
        else
        begin
            case (state_ff)
                LCC_C_OP:
                begin
                    if (rx_valid && rx_ready)
                    begin
                        opcode_ff <= rx_data; // R1
                        data_ff <= 32'h00000000;
                        left_ff <= len;
                        known_ff <= (len != 3'h0);
                        // unknown opcode carries no data, answered at once
                        state_ff <= (len == 3'h0) ? LCC_C_DONE : LCC_C_DATA;
                    end
                end
                LCC_C_DATA:
                begin
                    if (rx_valid && rx_ready)
                    begin
                        data_ff <= {data_ff[23:0], rx_data}; // R4
                        left_ff <= left_ff - 3'h1;
                        if (left_ff == 3'h1)
                        begin
                            state_ff <= LCC_C_DONE;
                        end
                    end
                end
                LCC_C_DONE:
                begin
                    state_ff <= LCC_C_OP;
                end
                default:
                begin
                    state_ff <= LCC_C_OP;
                end
            endcase
        end
    end
endmodule

// ### rtl/lcc_sender.sv
`timescale 1ns/1ps
module lcc_sender
    import lcc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic tx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic busy,
    lcc_cmd_if.sender rep
);
    logic pend_ff;
    logic [7:0] byte_ff;

    assign tx_valid = pend_ff;
    assign tx_data = byte_ff;
    // covers the cycle between decode and pending, so no byte slips in
    assign busy = pend_ff || rep.reply_valid;

    // ----------------------------------------
    // reply holding
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            pend_ff <= 1'b0;
            byte_ff <= 8'h00;
        end
        else if (rep.reply_valid)
        begin
            pend_ff <= 1'b1; // R2
            byte_ff <= rep.reply;
        end
        else if (tx_ready)
        begin
            pend_ff <= 1'b0;
        end
    end
endmodule

// ### rtl/lcc_config_parser.sv
`timescale 1ns/1ps
// Function
// R1: command is one opcode byte then its binary data bytes
// R2: every received command gets exactly one reply byte
// R3: reply 06h when valid, 15h for unknown opcode or bad data
// R4: multi-byte values travel most significant byte first
// R5: C1h sets integration time, 10 to 60000000 us, reset 5000
// R6: shutter when integration time at most 3709, else non-shutter
// R7: external sync mode ignores stored integration time
// R8: host should use at most 500 us before single-shot mode
// R9: C2h sets frames per acquisition, 1 to 4599, reset 1
// R10: with dummy pixels included the frame limit is 4541
// R11: frame count drives only onboard storage runs, not streaming
// R12: C3h selects operating mode 0 to 4, reset 0
// R13: C4h sets trigger advance 0 to 1849 us, reset 0
// R14: advance only in shutter and modes 0 to 3, otherwise zero
// R15: external sync ignores advance, trigger marks integration end
// R16: E1h enables trigger output, disabled after reset
// R17: host keeps trigger off while configuring
// R18: C5h sets dark correction, 0 or 1, reset 0
// R19: C9h selects dummy pixel output, 0 or 1, reset 0
// R20: dummy pixels included forces dark correction off
// R21: rejected command leaves the stored setting unchanged
// R22: single-byte enables accept only 0 and 1
module lcc_config_parser
    import lcc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire logic streaming,
    output logic [31:0] integ_time_us,
    output logic integ_time_used,
    output logic shutter_mode,
    output logic [2:0] op_mode,
    output logic ext_sync,
    output logic [31:0] frames_per_acq,
    output logic frame_limit_used,
    output logic [10:0] trig_advance_us,
    output logic trig_at_end,
    output logic trig_out_enable,
    output logic dark_corr_enable,
    output logic dummy_include
);
    lcc_cmd_if cmd_bus();

    logic busy;
    logic [31:0] integ_ff;
    logic [31:0] frames_ff;
    logic [2:0] mode_ff;
    logic [10:0] advance_ff;
    logic trig_en_ff;
    logic dark_ff;
    logic dummy_ff;
    logic ok;
    logic [31:0] frames_hi;
    logic is_ext;
    logic is_shutter;
    logic reply_valid_ff;
    logic [7:0] reply_ff;

    // ----------------------------------------
    // byte path
    // ----------------------------------------
    lcc_collector u_collector
    (
        .sys_clk(sys_clk),
        .reset(reset),
        .rx_valid(rx_valid),
        .rx_data(rx_data),
        .busy(busy),
        .rx_ready(rx_ready),
        .cmd(cmd_bus.collector)
    );

    lcc_sender u_sender
    (
        .sys_clk(sys_clk),
        .reset(reset),
        .tx_ready(tx_ready),
        .tx_valid(tx_valid),
        .tx_data(tx_data),
        .busy(busy),
        .rep(cmd_bus.sender)
    );

    // ----------------------------------------
    // validation
    // ----------------------------------------
    // limit follows the dummy setting in force when the command lands
    assign frames_hi = dummy_ff ? FRAMES_MAX_DUMMY : FRAMES_MAX; // R10

    always_comb
    begin
        ok = 1'b0;
        if (cmd_bus.known)
        begin
            case (cmd_bus.opcode)
                OP_INTEG: ok = lcc_in_range(cmd_bus.data, INTEG_MIN, INTEG_MAX); // R5
                OP_FRAMES: ok = lcc_in_range(cmd_bus.data, FRAMES_MIN, frames_hi); // R9
                OP_MODE: ok = (cmd_bus.data[7:0] <= {5'h00, MODE_MAX}); // R12
                OP_ADVANCE: ok = (cmd_bus.data <= ADVANCE_MAX); // R13
                OP_TRIG_EN, OP_DARK, OP_DUMMY: ok = (cmd_bus.data[7:1] == 7'h00); // R22
                default: ok = 1'b0;
            endcase
        end
    end

    // ----------------------------------------
    // reply
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            reply_valid_ff <= 1'b0;
            reply_ff <= 8'h00;
        end
        else
        begin
            reply_valid_ff <= cmd_bus.valid; // R2
            if (cmd_bus.valid)
            begin
                reply_ff <= ok ? REPLY_ACK : REPLY_NACK; // R3
            end
        end
    end

    assign cmd_bus.reply_valid = reply_valid_ff;
    assign cmd_bus.reply = reply_ff;

    // ----------------------------------------
    // settings store
    // ----------------------------------------
    // a refused command never reaches these writes
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            integ_ff <= INTEG_RST;
            frames_ff <= FRAMES_RST;
            mode_ff <= MODE_RST;
            advance_ff <= ADVANCE_RST[10:0];
            trig_en_ff <= 1'b0; // R16
            dark_ff <= 1'b0;
            dummy_ff <= 1'b0;
        end
        else if (cmd_bus.valid && ok) // R21
        begin
            case (cmd_bus.opcode)
                OP_INTEG: integ_ff <= cmd_bus.data; // R5
                OP_FRAMES: frames_ff <= cmd_bus.data; // R9
                OP_MODE: mode_ff <= cmd_bus.data[2:0]; // R12
                OP_ADVANCE: advance_ff <= cmd_bus.data[10:0]; // R13
                OP_TRIG_EN: trig_en_ff <= cmd_bus.data[0]; // R16
                OP_DARK: dark_ff <= cmd_bus.data[0]; // R18
                OP_DUMMY: dummy_ff <= cmd_bus.data[0]; // R19
                default: dummy_ff <= dummy_ff;
            endcase
        end
    end

    // ----------------------------------------
    // derived controls
    // ----------------------------------------
    assign is_ext = (mode_ff == MODE_EXT_SYNC);
    assign is_shutter = (integ_ff <= SHUTTER_MAX); // R6

    assign integ_time_us = integ_ff;
    assign integ_time_used = !is_ext; // R7
    assign shutter_mode = is_shutter; // R6
    assign op_mode = mode_ff;
    assign ext_sync = is_ext;
    assign frames_per_acq = frames_ff;
    // streaming runs until stopped, so the count is not in force then
    assign frame_limit_used = !streaming; // R11
    assign trig_advance_us = (is_shutter && !is_ext) ? advance_ff : 11'h000; // R14 R15
    assign trig_at_end = is_ext; // R15
    assign trig_out_enable = trig_en_ff; // R16
    assign dark_corr_enable = dark_ff && !dummy_ff; // R18 R20
    assign dummy_include = dummy_ff; // R19
endmodule

// ### verif/lcc_props.sv
`timescale 1ns/1ps
module lcc_props
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire logic streaming,
    input wire logic [31:0] integ_time_us,
    input wire logic integ_time_used,
    input wire logic shutter_mode,
    input wire logic [2:0] op_mode,
    input wire logic ext_sync,
    input wire logic frame_limit_used,
    input wire logic [10:0] trig_advance_us,
    input wire logic trig_at_end,
    input wire logic dark_corr_enable,
    input wire logic dummy_include
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    AST_CODE: assert property (tx_valid |-> tx_data == 8'h06 || tx_data == 8'h15)
        else $error("reply code");
    AST_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply dropped");
    AST_DONE: assert property (tx_valid && tx_ready |=> !tx_valid && rx_ready)
        else $error("reply not retired");
    AST_LOCK: assert property (tx_valid |-> !rx_ready)
        else $error("byte taken during reply");
    AST_SHUT: assert property (shutter_mode == (integ_time_us <= 32'h00000E7D))
        else $error("shutter select");
    AST_EXT: assert property (ext_sync == (op_mode == 3'h4) && trig_at_end == ext_sync
        && integ_time_used == !ext_sync)
        else $error("ext sync outputs");
    AST_ADV: assert property (!shutter_mode || ext_sync |-> trig_advance_us == 11'h000)
        else $error("advance not zeroed");
    AST_DARK: assert property (dummy_include |-> !dark_corr_enable)
        else $error("dark with dummy");
    AST_LIM: assert property (frame_limit_used == !streaming)
        else $error("frame limit use");
    AST_STAB: assert property (!$stable(integ_time_us) || !$stable(op_mode) |=> $rose(tx_valid))
        else $error("setting moved without reply");
    AST_KEEP: assert property ($rose(tx_valid) && tx_data == 8'h15 |->
        integ_time_us == $past(integ_time_us, 2) && op_mode == $past(op_mode, 2)
        && dummy_include == $past(dummy_include, 2))
        else $error("setting moved on reject");
endmodule

bind lcc_config_parser lcc_props u_props
(
    .sys_clk, .reset, .rx_ready, .tx_valid, .tx_data, .tx_ready, .streaming,
    .integ_time_us, .integ_time_used, .shutter_mode, .op_mode, .ext_sync,
    .frame_limit_used, .trig_advance_us, .trig_at_end, .dark_corr_enable, .dummy_include
);

// ### verif/lcc_host_model.sv
`timescale 1ns/1ps
module lcc_host_model
(
    input wire logic sys_clk,
    input wire logic rx_ready,
    input wire logic slow,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic tx_ready
);
    integer seed = 47;
    initial
    begin
        rx_valid = 1'b0;
        rx_data = 8'hFF;
        tx_ready = 1'b0;
    end
    // slow host stalls the reply at random
    always @(posedge sys_clk)
        tx_ready <= #1 slow ? $random(seed) : 1'b1;
    // opcode then n bytes, most significant first, no gap
    task automatic send(input logic [7:0] op, input logic [31:0] v, input int n);
        @(posedge sys_clk);
        #1 rx_valid = 1'b1;
        for (int i = n; i >= 0; i--)
        begin
            rx_data = (i == n) ? op : v[8*i +: 8];
            do @(posedge sys_clk); while (rx_ready !== 1'b1);
            #1;
        end
        // released line shows the inverse, not a stale byte
        rx_valid = 1'b0;
        rx_data = ~rx_data;
    endtask
endmodule

// ### verif/test_line_camera_config_command_parser.sv
`timescale 1ns/1ps
module test_line_camera_config_command_parser;
    logic sys_clk = 1'b0, reset = 1'b1, streaming = 1'b0, slow = 1'b0;
    logic rx_valid, rx_ready, tx_valid, tx_ready, integ_time_used, shutter_mode, ext_sync;
    logic frame_limit_used, trig_at_end, trig_out_enable, dark_corr_enable, dummy_include;
    logic [7:0] rx_data, tx_data;
    logic [31:0] integ_time_us, frames_per_acq;
    logic [2:0] op_mode;
    logic [10:0] trig_advance_us;
    logic [31:0] m_int = 32'h00001388, m_frm = 32'h00000001, m_adv = 32'h00000000;
    logic [2:0] m_mode = 3'h0;
    logic m_trig = 1'b0, m_dark = 1'b0, m_dum = 1'b0;
    logic [7:0] expq[$];
    int err_total = 0, checks = 0, cyc = 0;
    integer seed = 47;
    logic [7:0] ops[] = '{8'hC1, 8'hC1, 8'hC1, 8'hC1, 8'hC1, 8'hC1, 8'hC1, 8'hC2, 8'hC2,
        8'hC2, 8'hC9, 8'hC2, 8'hC2, 8'hC5, 8'hC9, 8'hC9, 8'hC5, 8'hC4, 8'hC4, 8'hC3,
        8'hC3, 8'hC3, 8'hC3, 8'hC1, 8'hC3, 8'hC3, 8'hAA, 8'hE1, 8'hE1, 8'hC5};
    logic [31:0] vals[] = '{9, 10, 3709, 3710, 60000000, 60000001, 32'h01000000, 0, 4599,
        4600, 1, 4542, 4541, 1, 2, 0, 2, 1849, 1850, 5, 1, 2, 4, 100, 3, 0, 0, 2, 1, 0};

    lcc_config_parser dut
    (
        .sys_clk, .reset, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready,
        .streaming, .integ_time_us, .integ_time_used, .shutter_mode, .op_mode, .ext_sync,
        .frames_per_acq, .frame_limit_used, .trig_advance_us, .trig_at_end,
        .trig_out_enable, .dark_corr_enable, .dummy_include
    );
    lcc_host_model host
    (
        .sys_clk, .rx_ready, .slow, .rx_valid, .rx_data, .tx_ready
    );

    initial
    begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic close_out;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic cmp_all;
        logic sh;
        sh = m_int <= 3709;
        chk("integ", integ_time_us, m_int);
        chk("shutter", shutter_mode, sh);
        chk("used", integ_time_used, m_mode != 4);
        chk("mode", op_mode, m_mode);
        chk("ext", {ext_sync, trig_at_end}, {2{m_mode == 4}});
        chk("frames", frames_per_acq, m_frm);
        chk("limit", frame_limit_used, !streaming);
        chk("adv", trig_advance_us, (sh && m_mode != 4) ? m_adv : 0);
        chk("trig", trig_out_enable, m_trig);
        chk("dark", dark_corr_enable, m_dark && !m_dum);
        chk("dummy", dummy_include, m_dum);
    endtask

    task automatic cmd(input logic [7:0] op, input logic [31:0] v);
        logic ok;
        int n;
        int w;
        n = (op inside {8'hC1, 8'hC2, 8'hC4}) ? 4 : (op inside {8'hC3, 8'hC5, 8'hC9, 8'hE1});
        // only the low byte travels for one-byte commands
        if (n == 1)
            v = {24'h000000, v[7:0]};
        case (op)
            8'hC1: ok = v >= 10 && v <= 60000000;
            8'hC2: ok = v >= 1 && v <= (m_dum ? 4541 : 4599);
            8'hC3: ok = v <= 4;
            8'hC4: ok = v <= 1849;
            8'hE1, 8'hC5, 8'hC9: ok = v <= 1;
            default: ok = 1'b0;
        endcase
        expq.push_back(ok ? 8'h06 : 8'h15);
        host.send(op, v, n);
        for (w = 0; w < 200 && expq.size() > 0; w++)
            @(posedge sys_clk);
        #1;
        chk("reply wait", expq.size(), 0);
        if (ok)
            case (op)
                8'hC1: m_int = v;
                8'hC2: m_frm = v;
                8'hC3: m_mode = v[2:0];
                8'hC4: m_adv = v;
                8'hE1: m_trig = v[0];
                8'hC5: m_dark = v[0];
                8'hC9: m_dum = v[0];
            endcase
        cmp_all();
    endtask

    // ----------------------------------------
    // reply scoreboard
    // ----------------------------------------
    always @(posedge sys_clk)
        if (tx_valid === 1'b1 && tx_ready === 1'b1)
        begin
            if (expq.size() == 0)
                chk("extra reply", 1, 0);
            else
                chk("reply", tx_data, expq.pop_front());
        end

    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            err_total++;
            close_out();
        end
    end

    initial
    begin
        repeat (20) @(posedge sys_clk);
        #1 reset = 1'b0;
        cmp_all();
        // trigger enabled just before the final dark command, small time before single-shot
        foreach (ops[i])
        begin
            slow = i > 12;
            cmd(ops[i], vals[i]);
        end
        repeat (12)
        begin
            streaming = $random(seed);
            cmd(ops[{$random(seed)} % 30], {$random(seed)} % 32'h04000000);
        end
        close_out();
    end
endmodule
